//--- shared/pies_pkg.sv
// Purpose: Constants for the initiator error status block.
// Assumes: 32-bit register port, 16-bit byte addresses, one clock.
// Notes: Every offset, field position, reset value and count lives here.
// How it works
// - A TRDY wait longer than the limit sets status bit 1.
// - A retry count over the limit sets status bit 0.
// - Both flags reset to zero, stay set, clear only on writing one.
// - Enable bit 1 lets the TRDY timeout flag raise the interrupt.
// - Enable bit 0 lets the retry limit flag raise the interrupt.
// - In card mode local writes to config status and power control are blocked.
// - Card status bits 25:24 mirror the host power state, read only.
// - Card status bit 23 mirrors the power event enable, read only.
// - Card status bits 15 and 8 mirror the parity error bits.
// - Card status bits 14 to 11 mirror the system error and abort bits.
// - Card status bits 10:9 always read 01.
// - Retry limit field 15:8, default 0x80, zero disables the check.
// - TRDY wait field 7:0, default 0x80, zero disables the check.
package pies_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LIMIT_W = 8;

    localparam logic [15:0] OFF_TIMEOUT_COUNT = 16'hd040;
    localparam logic [15:0] OFF_ERR_STATUS = 16'hd080;
    localparam logic [15:0] OFF_IRQ_EN = 16'hd084;
    localparam logic [15:0] OFF_CARD_STATUS = 16'hd088;
    localparam logic [15:0] OFF_CFG_STATUS_CMD = 16'hd0a0;
    localparam logic [15:0] OFF_CFG_PMCSR = 16'hd0a4;

    localparam int BIT_TRDY = 1;
    localparam int BIT_RETRY = 0;
    localparam int RETRY_LSB = 8;
    localparam int TRDY_LSB = 0;
    localparam logic [7:0] RETRY_LIMIT_RST = 8'h80;
    localparam logic [7:0] TRDY_LIMIT_RST = 8'h80;
    localparam logic [1:0] ERR_RST = 2'h0;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;

    // Host shadow vector layout as it arrives on i_host_shadow.
    localparam int SHW_W = 9;
    localparam int SHW_PS_LSB = 7;
    localparam int SHW_PME = 6;
    localparam int SHW_DPE = 5;
    localparam int SHW_SSE = 4;
    localparam int SHW_RMA = 3;
    localparam int SHW_RTA = 2;
    localparam int SHW_STA = 1;
    localparam int SHW_MASTER_PARITY_ERROR_COPY = 0;
    localparam logic [8:0] SHW_RST = 9'h000;

    // Field positions inside the card mode status copy.
    localparam int CS_PS_LSB = 24;
    localparam int CS_PME = 23;
    localparam int CS_DPE = 15;
    localparam int CS_SSE = 14;
    localparam int CS_RMA = 13;
    localparam int CS_RTA = 12;
    localparam int CS_STA = 11;
    localparam int CS_DT_LSB = 9;
    localparam int CS_MASTER_PARITY_ERROR_COPY = 8;
    localparam logic [1:0] DEVSEL_TIMING = 2'h1;

    typedef enum logic [2:0] {
        PIES_IDLE = 3'b001,
        PIES_WAIT = 3'b010,
        PIES_HELD = 3'b100
    } pies_wait_state_t;
endpackage

//--- shared/pies_ifc.sv
`timescale 1ns/100ps
// Purpose: Carries limits, initiator activity and timeout events.
// Assumes: Both ends run on the register clock.
// Notes: Timeout events are one-cycle pulses.
interface pies_ifc;
    logic [7:0] trdy_limit;
    logic [7:0] retry_limit;
    logic wait_trdy;
    logic retry_term;
    logic txn_end;
    logic trdy_timeout;
    logic retry_timeout;

    modport ctl (
        output trdy_limit,
        output retry_limit,
        output wait_trdy,
        output retry_term,
        output txn_end,
        input trdy_timeout,
        input retry_timeout
    );

    modport det (
        input trdy_limit,
        input retry_limit,
        input wait_trdy,
        input retry_term,
        input txn_end,
        output trdy_timeout,
        output retry_timeout
    );
endinterface

//--- core/pies_sync.sv
`timescale 1ns/100ps
// Purpose: Two-flop synchroniser for a bundle of slow levels.
// Assumes: Bits change rarely; bundles may be torn across one cycle.
// Notes: The first stage is read only by the second stage.
module pies_sync #(
    parameter int W = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb
    begin
        next_meta = i_async;
        next_sync = meta;
        if (i_reset)
        begin
            next_meta = '0;
            next_sync = '0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        meta <= next_meta;
        o_sync <= next_sync;
    end
endmodule

//--- core/pies_timeout.sv
`timescale 1ns/100ps
// Purpose: Detects TRDY wait and retry count overruns of the initiator.
// Assumes: Initiator activity signals are on the register clock.
// Notes: A limit of zero turns its check off.
module pies_timeout (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    pies_ifc.det bus
);
    pies_pkg::pies_wait_state_t state;
    pies_pkg::pies_wait_state_t next_state;
    logic [7:0] wait_cnt;
    logic [7:0] next_wait_cnt;
    logic [7:0] retry_cnt;
    logic [7:0] next_retry_cnt;
    logic trdy_ev;
    logic next_trdy_ev;
    logic retry_ev;
    logic next_retry_ev;

    always_comb
    begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_trdy_ev = 1'b0;
        case (state)
            pies_pkg::PIES_IDLE:
            begin
                if (bus.wait_trdy && bus.trdy_limit != 8'h00)
                begin
                    next_state = pies_pkg::PIES_WAIT;
                    next_wait_cnt = 8'h01;
                end
            end
            pies_pkg::PIES_WAIT:
            begin
                if (!bus.wait_trdy || bus.trdy_limit == 8'h00)
                begin
                    next_state = pies_pkg::PIES_IDLE;
                end
                else if (wait_cnt >= bus.trdy_limit)
                begin
                    // One event per stall; HELD waits for the stall to end.
                    next_state = pies_pkg::PIES_HELD;
                    next_trdy_ev = 1'b1;
                end
                else
                begin
                    next_wait_cnt = wait_cnt + 8'h01;
                end
            end
            pies_pkg::PIES_HELD:
            begin
                if (!bus.wait_trdy)
                begin
                    next_state = pies_pkg::PIES_IDLE;
                end
            end
            default:
            begin
                next_state = pies_pkg::PIES_IDLE;
            end
        endcase

        next_retry_cnt = retry_cnt;
        next_retry_ev = 1'b0;
        if (bus.txn_end)
        begin
            next_retry_cnt = 8'h00;
        end
        else if (bus.retry_term)
        begin
            if (bus.retry_limit != 8'h00 && retry_cnt >= bus.retry_limit)
            begin
                next_retry_ev = 1'b1;
                next_retry_cnt = 8'h00;
            end
            else if (retry_cnt != 8'hff)
            begin
                next_retry_cnt = retry_cnt + 8'h01;
            end
        end

        if (i_reset)
        begin
            next_state = pies_pkg::PIES_IDLE;
            next_wait_cnt = 8'h00;
            next_trdy_ev = 1'b0;
            next_retry_cnt = 8'h00;
            next_retry_ev = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        state <= next_state;
        wait_cnt <= next_wait_cnt;
        trdy_ev <= next_trdy_ev;
        retry_cnt <= next_retry_cnt;
        retry_ev <= next_retry_ev;
    end

    assign bus.trdy_timeout = trdy_ev;
    assign bus.retry_timeout = retry_ev;
endmodule

//--- core/pies_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
// Purpose: Initiator error flags, interrupt enables and card mode status copy.
// Assumes: Host shadow bits and card mode strap come from another domain.
// Notes: Read data stand only in the cycle after the read strobe.
module pies_top (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_init_wait_trdy,
    input wire logic i_init_retry_term,
    input wire logic i_init_txn_end,
    input wire logic i_card_mode,
    input wire logic [8:0] i_host_shadow,
    input wire logic [31:0] i_cfg_status_cmd,
    input wire logic [31:0] i_cfg_pmcsr,
    output logic o_cfg_wr_status_cmd,
    output logic o_cfg_wr_pmcsr,
    output logic [31:0] o_cfg_wdata,
    output logic o_init_abort,
    output logic o_card_mode,
    output logic o_irq
);
    pies_ifc det_bus ();

    logic card_mode_s;
    logic [8:0] shadow_s;
    logic [15:0] timeout_count;
    logic [15:0] next_timeout_count;
    logic [1:0] err_flags;
    logic [1:0] next_err_flags;
    logic [1:0] irq_en;
    logic [1:0] next_irq_en;
    logic [8:0] shadow;
    logic [8:0] next_shadow;
    logic [31:0] next_rdata;
    logic next_irq;
    logic next_cfg_wr_status_cmd;
    logic next_cfg_wr_pmcsr;
    logic [31:0] next_cfg_wdata;
    logic next_init_abort;
    logic next_card_mode;
    logic [1:0] events;
    logic [1:0] clear_mask;
    logic [31:0] card_status_word;

    pies_sync #(
        .W(1)
    ) u_mode_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_async(i_card_mode),
        .o_sync(card_mode_s)
    );

    // The shadow bits may be torn for a cycle while the host changes them,
    // which is why software should read the power state twice in a row.
    pies_sync #(
        .W(pies_pkg::SHW_W)
    ) u_shadow_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_async(i_host_shadow),
        .o_sync(shadow_s)
    );

    pies_timeout u_timeout (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .bus(det_bus.det)
    );

    assign det_bus.trdy_limit = timeout_count[pies_pkg::TRDY_LSB +: pies_pkg::LIMIT_W];
    assign det_bus.retry_limit = timeout_count[pies_pkg::RETRY_LSB +: pies_pkg::LIMIT_W];
    assign det_bus.wait_trdy = i_init_wait_trdy;
    assign det_bus.retry_term = i_init_retry_term;
    assign det_bus.txn_end = i_init_txn_end;

    always_comb
    begin
        card_status_word = 32'h0000_0000;
        card_status_word[pies_pkg::CS_PS_LSB +: 2] = shadow[pies_pkg::SHW_PS_LSB +: 2];
        card_status_word[pies_pkg::CS_PME] = shadow[pies_pkg::SHW_PME];
        card_status_word[pies_pkg::CS_DPE] = shadow[pies_pkg::SHW_DPE];
        card_status_word[pies_pkg::CS_MASTER_PARITY_ERROR_COPY] = shadow[pies_pkg::SHW_MASTER_PARITY_ERROR_COPY];
        card_status_word[pies_pkg::CS_SSE] = shadow[pies_pkg::SHW_SSE];
        card_status_word[pies_pkg::CS_RMA] = shadow[pies_pkg::SHW_RMA];
        card_status_word[pies_pkg::CS_RTA] = shadow[pies_pkg::SHW_RTA];
        card_status_word[pies_pkg::CS_STA] = shadow[pies_pkg::SHW_STA];
        card_status_word[pies_pkg::CS_DT_LSB +: 2] = pies_pkg::DEVSEL_TIMING;
    end

    always_comb
    begin
        events = 2'h0;
        events[pies_pkg::BIT_TRDY] = det_bus.trdy_timeout;
        events[pies_pkg::BIT_RETRY] = det_bus.retry_timeout;

        clear_mask = 2'h0;
        if (i_wr && i_addr == pies_pkg::OFF_ERR_STATUS)
        begin
            clear_mask = i_wdata[1:0];
        end
        // A new event in the clearing cycle wins, so no timeout is lost.
        next_err_flags = (err_flags & ~clear_mask) | events;

        if (i_reset)
        begin
            next_err_flags = pies_pkg::ERR_RST;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        err_flags <= next_err_flags;
    end

    always_comb
    begin
        next_irq_en = irq_en;
        if (i_wr && i_addr == pies_pkg::OFF_IRQ_EN)
        begin
            next_irq_en = i_wdata[1:0];
        end

        if (i_reset)
        begin
            next_irq_en = pies_pkg::IRQ_EN_RST;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        irq_en <= next_irq_en;
    end

    // The detector reads the limits straight from this register, so a new
    // limit also applies to a stall that is already being counted.
    always_comb
    begin
        next_timeout_count = timeout_count;
        if (i_wr && i_addr == pies_pkg::OFF_TIMEOUT_COUNT)
        begin
            next_timeout_count = i_wdata[15:0];
        end

        if (i_reset)
        begin
            next_timeout_count = {pies_pkg::RETRY_LIMIT_RST, pies_pkg::TRDY_LIMIT_RST};
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        timeout_count <= next_timeout_count;
    end

    // The copy follows the host in every mode. Local writes never reach it,
    // so a card that writes its own status cannot disturb the mirror.
    always_comb
    begin
        next_shadow = shadow_s;

        if (i_reset)
        begin
            next_shadow = pies_pkg::SHW_RST;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        shadow <= next_shadow;
    end

    // The synchronised strap is registered once more so that it leaves as a flop.
    always_comb
    begin
        next_card_mode = card_mode_s;

        if (i_reset)
        begin
            next_card_mode = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_card_mode <= next_card_mode;
    end

    // Gating on the registered mode keeps the write pulses in step with
    // o_card_mode as the outside sees it; a strap change costs one cycle.
    always_comb
    begin
        next_cfg_wr_status_cmd = i_wr && i_addr == pies_pkg::OFF_CFG_STATUS_CMD && !o_card_mode;
        next_cfg_wr_pmcsr = i_wr && i_addr == pies_pkg::OFF_CFG_PMCSR && !o_card_mode;

        if (i_reset)
        begin
            next_cfg_wr_status_cmd = 1'b0;
            next_cfg_wr_pmcsr = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_cfg_wr_status_cmd <= next_cfg_wr_status_cmd;
        o_cfg_wr_pmcsr <= next_cfg_wr_pmcsr;
    end

    always_comb
    begin
        next_cfg_wdata = o_cfg_wdata;
        if (next_cfg_wr_status_cmd || next_cfg_wr_pmcsr)
        begin
            next_cfg_wdata = i_wdata;
        end

        if (i_reset)
        begin
            next_cfg_wdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_cfg_wdata <= next_cfg_wdata;
    end

    // The abort pulse ends the initiator's transaction with an error.
    always_comb
    begin
        next_init_abort = det_bus.trdy_timeout || det_bus.retry_timeout;

        if (i_reset)
        begin
            next_init_abort = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_init_abort <= next_init_abort;
    end

    // Read data fall back to zero outside the answer cycle, so a stale word
    // is never mistaken for a fresh one.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (i_rd)
        begin
            case (i_addr)
                pies_pkg::OFF_TIMEOUT_COUNT:
                begin
                    next_rdata = {16'h0000, timeout_count};
                end
                pies_pkg::OFF_ERR_STATUS:
                begin
                    next_rdata = {30'h0000_0000, err_flags};
                end
                pies_pkg::OFF_IRQ_EN:
                begin
                    next_rdata = {30'h0000_0000, irq_en};
                end
                pies_pkg::OFF_CARD_STATUS:
                begin
                    next_rdata = card_status_word;
                end
                pies_pkg::OFF_CFG_STATUS_CMD:
                begin
                    next_rdata = i_cfg_status_cmd;
                end
                pies_pkg::OFF_CFG_PMCSR:
                begin
                    next_rdata = i_cfg_pmcsr;
                end
                default:
                begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end

        if (i_reset)
        begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_rdata <= next_rdata;
    end

    // Computed from next values so the output flop changes at the same edge
    // as the flags; a flag and its interrupt never disagree for a cycle.
    always_comb
    begin
        next_irq = |(next_err_flags & next_irq_en);
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_irq <= next_irq;
    end
endmodule

//--- tb/pies_top_monitor.sv
// Purpose: Port-level checker for the initiator error status block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Card mode is stable around config writes in every scenario.
`timescale 1ns/100ps
module pies_top_monitor (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_cfg_wr_status_cmd,
    input wire logic o_cfg_wr_pmcsr,
    input wire logic [31:0] o_cfg_wdata,
    input wire logic o_init_abort,
    input wire logic o_card_mode,
    input wire logic o_irq
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_rd(logic [15:0] a);
        i_rd && i_addr == a;
    endsequence
    sequence s_open_wr(logic [15:0] a);
        i_wr && i_addr == a && !o_card_mode;
    endsequence
    a_abort_one_cycle: assert property (o_init_abort |=> !o_init_abort)
        else $error("abort pulse lasted more than one cycle");
    a_irq_rise_cause: assert property ($rose(o_irq) |-> o_init_abort || $past(i_wr))
        else $error("interrupt rose without an error or a write");
    a_irq_fall_cause: assert property ($fell(o_irq) |-> $past(i_wr))
        else $error("interrupt fell without a write");
    a_status_rsvd_zero: assert property (s_rd(pies_pkg::OFF_ERR_STATUS) |=> o_rdata[31:2] == 30'h0)
        else $error("status reserved bits not zero");
    a_card_fixed_bits: assert property (s_rd(pies_pkg::OFF_CARD_STATUS) |=>
        o_rdata[10:9] == pies_pkg::DEVSEL_TIMING && o_rdata[22:16] == 7'h00 && o_rdata[7:0] == 8'h00)
        else $error("card status fixed bits wrong");
    a_sc_write_pass: assert property (s_open_wr(pies_pkg::OFF_CFG_STATUS_CMD) |=>
        o_cfg_wr_status_cmd && o_cfg_wdata == $past(i_wdata))
        else $error("status command write not passed on");
    a_pm_write_pass: assert property (s_open_wr(pies_pkg::OFF_CFG_PMCSR) |=>
        o_cfg_wr_pmcsr && o_cfg_wdata == $past(i_wdata))
        else $error("power control write not passed on");
    a_pm_write_gate: assert property (o_cfg_wr_pmcsr |->
        $past(i_wr) && $past(i_addr) == pies_pkg::OFF_CFG_PMCSR && !$past(o_card_mode))
        else $error("power control write pulse without an open write");
endmodule
bind pies_top pies_top_monitor i_pies_top_monitor (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cfg_wr_status_cmd(o_cfg_wr_status_cmd),
    .o_cfg_wr_pmcsr(o_cfg_wr_pmcsr), .o_cfg_wdata(o_cfg_wdata), .o_init_abort(o_init_abort),
    .o_card_mode(o_card_mode), .o_irq(o_irq));

//--- tb/pies_far_side.sv
// Purpose: Bus side model: initiator activity and config space registers.
// Assumes: Same clock as the block; one burst at a time.
// Notes: A burst of n cycles is a TRDY stall, or (n-1)/2 retries then a transaction end.
`timescale 1ns/100ps
module pies_far_side (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic i_retry,
    input wire logic [7:0] i_len,
    input wire logic i_cfg_wr_sc,
    input wire logic i_cfg_wr_pm,
    input wire logic [31:0] i_cfg_wdata,
    output logic o_wait_trdy,
    output logic o_retry_term,
    output logic o_txn_end,
    output logic [31:0] o_cfg_sc,
    output logic [31:0] o_cfg_pm
);
    logic [7:0] cnt;
    logic retry;
    // Retries are spaced a cycle apart, as a real target cannot retry every clock.
    assign o_wait_trdy = cnt != 8'h00 && !retry;
    assign o_retry_term = retry && cnt > 8'h01 && cnt[0];
    assign o_txn_end = retry && cnt == 8'h01;
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            cnt <= 8'h00;
            retry <= 1'b0;
            o_cfg_sc <= 32'h0000_0000;
            o_cfg_pm <= 32'h0000_0000;
        end
        else
        begin
            if (i_go)
            begin
                cnt <= i_len;
                retry <= i_retry;
            end
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
            if (i_cfg_wr_sc)
                o_cfg_sc <= i_cfg_wdata;
            if (i_cfg_wr_pm)
                o_cfg_pm <= i_cfg_wdata;
        end
    end
endmodule

//--- tb/pies_top_tb.sv
// Purpose: Self-checking bench for the initiator error status block.
// Assumes: One 10 MHz clock, synchronous reset.
// Notes: Limits are set small so every timeout fits in a few cycles.
`timescale 1ns/100ps
module pies_top_tb;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, go = 1'b0, retry = 1'b0, card = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [7:0] len = 8'h00;
    logic [8:0] shadow = 9'h000;
    logic [31:0] rdata, cfg_sc, cfg_pm, cfg_wdata;
    logic wt, rt, te, cfg_wr_sc, cfg_wr_pm, abort, card_o, irq;
    int errors = 0, compares = 0;
    int pos [9] = '{8, 11, 12, 13, 14, 15, 23, 24, 25};
    pies_top i_pies_top (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .i_init_wait_trdy(wt), .i_init_retry_term(rt), .i_init_txn_end(te),
        .i_card_mode(card), .i_host_shadow(shadow), .i_cfg_status_cmd(cfg_sc), .i_cfg_pmcsr(cfg_pm),
        .o_cfg_wr_status_cmd(cfg_wr_sc), .o_cfg_wr_pmcsr(cfg_wr_pm), .o_cfg_wdata(cfg_wdata),
        .o_init_abort(abort), .o_card_mode(card_o), .o_irq(irq));
    pies_far_side i_pies_far_side (.i_ref_clk(clk), .i_reset(rst), .i_go(go), .i_retry(retry), .i_len(len),
        .i_cfg_wr_sc(cfg_wr_sc), .i_cfg_wr_pm(cfg_wr_pm), .i_cfg_wdata(cfg_wdata), .o_wait_trdy(wt),
        .o_retry_term(rt), .o_txn_end(te), .o_cfg_sc(cfg_sc), .o_cfg_pm(cfg_pm));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        // Outputs launched by this edge settle before any caller looks at them.
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic act(input logic r, input logic [7:0] n);
        @(posedge clk);
        go <= 1'b1;
        retry <= r;
        len <= n;
        @(posedge clk);
        go <= 1'b0;
        repeat (n + 8) @(posedge clk);
    endtask
    task automatic t_reset;
        rd(pies_pkg::OFF_TIMEOUT_COUNT, 32'h0000_8080);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0000);
        rd(pies_pkg::OFF_IRQ_EN, 32'h0000_0000);
        rd(pies_pkg::OFF_CARD_STATUS, 32'h0000_0200);
        rd(16'hd0fc, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic t_trdy;
        wr(pies_pkg::OFF_TIMEOUT_COUNT, 32'h0000_0203);
        wr(pies_pkg::OFF_IRQ_EN, 32'h0000_0002);
        rd(pies_pkg::OFF_IRQ_EN, 32'h0000_0002);
        act(1'b0, 8'h03);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0000);
        act(1'b0, 8'h04);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
    endtask
    task automatic t_retry;
        act(1'b1, 8'h05);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0002);
        act(1'b1, 8'h07);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0003);
        wr(pies_pkg::OFF_ERR_STATUS, 32'h0000_0000);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0003);
        wr(pies_pkg::OFF_ERR_STATUS, 32'h0000_0002);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(pies_pkg::OFF_IRQ_EN, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(pies_pkg::OFF_ERR_STATUS, 32'h0000_0001);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic t_disable;
        wr(pies_pkg::OFF_TIMEOUT_COUNT, 32'h0000_0000);
        act(1'b0, 8'h14);
        act(1'b1, 8'h15);
        rd(pies_pkg::OFF_ERR_STATUS, 32'h0000_0000);
    endtask
    task automatic t_shadow;
        for (int k = 0; k < 9; k++)
        begin
            @(posedge clk);
            shadow <= 9'h001 << k;
            repeat (4) @(posedge clk);
            rd(pies_pkg::OFF_CARD_STATUS, 32'h0000_0200 | (32'h0000_0001 << pos[k]));
            rd(pies_pkg::OFF_CARD_STATUS, 32'h0000_0200 | (32'h0000_0001 << pos[k]));
        end
        wr(pies_pkg::OFF_CARD_STATUS, 32'hffff_ffff);
        rd(pies_pkg::OFF_CARD_STATUS, 32'h0200_0200);
    endtask
    task automatic t_card;
        wr(pies_pkg::OFF_CFG_STATUS_CMD, 32'h1234_5678);
        rd(pies_pkg::OFF_CFG_STATUS_CMD, 32'h1234_5678);
        wr(pies_pkg::OFF_CFG_PMCSR, 32'h0000_0100);
        @(posedge clk);
        card <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, card_o}, 32'h0000_0001);
        wr(pies_pkg::OFF_CFG_PMCSR, 32'h0000_0003);
        wr(pies_pkg::OFF_CFG_STATUS_CMD, 32'h0000_0000);
        rd(pies_pkg::OFF_CFG_PMCSR, 32'h0000_0100);
        rd(pies_pkg::OFF_CFG_STATUS_CMD, 32'h1234_5678);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trdy();
        t_retry();
        t_disable();
        t_shadow();
        t_card();
        tally_and_finish();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule
